// ===== rtl/tfs_top.sv
// Tape fault detection and stop sequencing with AXI4-Lite register access
// Assumes drive-side event inputs are synchronous one-cycle pulses or levels
//
// Operation
// - Fault after motion start stops tape, B-stop
// - Fault stop waits for end of block
// - Stop command clears word, command, block counter
// - Computer stop follows fault by 80 ms
// - Stop command without drive enters lockout
// - Master clear halts erroneous tape motion
// - Computer stop lets rewind, move finish
// - Computer stop halts read/write at block end
// - Buffer-fault and tape-fault indicators separate
// - Lockout shows wait line, instruction kept
// - Instruction and next-address registers held
// - Over-temperature raises A-class fault
// - Drive interlock raises B-class fault
// - Missing data raises B-class fault
// - Selection and sprocket errors raise B-class
// - Parity checked over block's 720 lines
// - Parity error sets status bit, stops
// - Clean block sends only read acknowledge
// - Parity error never raises computer fault
// - Master clear clears fault conditions, indicators
`include "tfs_regs.svh"
module tfs_top import tfs_pkg::*; #(
   parameter int unsigned STOP_DELAY_CYC = `TFS_STOP_DELAY_CYC
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_NRST,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   input  wire logic        I_BLOCK_END,
   input  wire logic        I_LINE_VALID,
   input  wire logic        I_LINE_PERR,
   input  wire logic        I_REWIND_DONE,
   input  wire logic        I_COMP_STOP,
   input  wire logic        I_CLEAR_A,
   input  wire logic        I_TEMP_FAULT,
   input  wire logic        I_INTERLOCK_FAULT,
   input  wire logic        I_MISSING_DATA,
   input  wire logic        I_SELECT_ERR,
   input  wire logic        I_SPROCKET_ERR,
   input  wire logic        I_READ_OVERRUN,
   output logic             O_TAPE_RUN,
   output logic [3:0]       O_DRIVE_SEL,
   output logic             O_TAPE_STOP,
   output logic             O_READ_ACK,
   output logic             O_A_FAULT,
   output logic             O_B_STOP,
   output logic             O_TAPE_FLT_IND,
   output logic             O_BUF_FAULT_IND,
   output logic             O_WAIT_EXT
);
   // =======================================================================
   // State
   tfs_state_type state;
   tfs_state_type next_state;
   logic [31:0]   tape_command_register;
   logic [31:0]   tape_word_register;
   logic [31:0]   block_counter;
   logic [31:0]   instruction_register;
   logic [31:0]   next_address_counter;
   logic          isb_perr;
   logic          blk_perr;
   logic [9:0]    line_cnt;
   logic          lockout;
   logic          temp_flt;
   logic [4:0]    b_flt;
   logic [23:0]   delay_cnt;
   logic          delay_run;
   logic          b_stop;
   logic          read_ack;
   logic          tape_stop;
   logic [7:0]    aw_addr;
   logic          aw_full;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          w_full;
   logic          bvalid;
   logic [1:0]    bresp;
   logic          rvalid;
   logic [31:0]   rdata;
   logic [1:0]    rresp;

   // =======================================================================
   // Bus decode
   wire          do_wr     = aw_full && w_full && !bvalid;
   wire          do_rd     = I_ARVALID && !rvalid;
   wire [31:0]   wmask     = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire          wr_cmd    = do_wr && aw_addr == `TFS_OFF_CMD;
   wire          wr_twr    = do_wr && aw_addr == `TFS_OFF_TWR;
   wire          wr_blk    = do_wr && aw_addr == `TFS_OFF_BLK;
   wire          wr_ir     = do_wr && aw_addr == `TFS_OFF_IR;
   wire          wr_nac    = do_wr && aw_addr == `TFS_OFF_NAC;
   wire          wr_hit    = wr_cmd || wr_twr || wr_blk || wr_ir || wr_nac;
   wire          rd_isb    = do_rd && I_ARADDR == `TFS_OFF_ISB;
   wire [31:0]   cmd_new   = (tape_command_register & ~wmask) | (w_data & wmask);
   wire [3:0]    new_drv   = cmd_new[`TFS_CMD_DRV_MSB:`TFS_CMD_DRV_LSB];
   wire [2:0]    new_op    = cmd_new[`TFS_CMD_OP_MSB:`TFS_CMD_OP_LSB];
   wire [3:0]    cur_drv   = tape_command_register[`TFS_CMD_DRV_MSB:`TFS_CMD_DRV_LSB];
   wire [2:0]    cur_op    = tape_command_register[`TFS_CMD_OP_MSB:`TFS_CMD_OP_LSB];

   // =======================================================================
   // Fault classes and stop causes
   wire          b_any     = |b_flt;
   wire          b_new     = I_INTERLOCK_FAULT || I_MISSING_DATA || I_SELECT_ERR
                             || I_SPROCKET_ERR || I_READ_OVERRUN;
   wire          comp_halt = I_COMP_STOP || b_stop || temp_flt;
   wire          is_read   = cur_op == OP_READ;
   wire          perr_now  = blk_perr || (I_LINE_VALID && I_LINE_PERR);
   wire          blk_chk   = I_BLOCK_END && is_read && state != ST_IDLE;
   wire          perr_stop = blk_chk && perr_now;
   wire          long_op   = cur_op == OP_MOVE || cur_op == OP_REWIND;
   wire          mv_done   = I_BLOCK_END && cur_op == OP_MOVE && block_counter <= 32'h1;
   wire          op_done   = mv_done || (I_REWIND_DONE && cur_op == OP_REWIND);
   wire          start_ok  = new_op inside {OP_READ, OP_WRITE, OP_MOVE, OP_REWIND}
                             && new_drv != 4'h0;
   wire          stop_nodrv = wr_cmd && new_op == OP_STOP && new_drv == 4'h0;
   wire          stop_cmd  = wr_cmd && new_op == OP_STOP && new_drv != 4'h0;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_cmd && start_ok && !lockout) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (b_new || b_any || perr_stop || stop_cmd) begin
               next_state = perr_stop ? ST_IDLE : ST_HALT_BLK;
            end else if (op_done) begin
               next_state = ST_IDLE;
            end else if (comp_halt) begin
               next_state = long_op ? ST_HALT_OP : ST_HALT_BLK;
            end
         end
         ST_HALT_BLK: begin
            if (I_BLOCK_END) begin
               next_state = ST_IDLE;
            end
         end
         ST_HALT_OP: begin
            if (b_new || perr_stop) begin
               next_state = perr_stop ? ST_IDLE : ST_HALT_BLK;
            end else if (op_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   wire          stopping  = state != ST_IDLE && next_state == ST_IDLE;

   // =======================================================================
   // Motion sequencer; master clear drops motion at once
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state     <= ST_IDLE;
         tape_stop <= 1'b0;
      end else begin
         state     <= next_state;
         tape_stop <= stopping;
      end
   end

   // =======================================================================
   // Tape registers, cleared as the stop goes out to the drive
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         tape_command_register <= `TFS_RST_WORD;
         tape_word_register    <= `TFS_RST_WORD;
         block_counter         <= `TFS_RST_WORD;
      end else if (stopping) begin
         tape_command_register <= `TFS_RST_WORD;
         tape_word_register    <= `TFS_RST_WORD;
         block_counter         <= `TFS_RST_WORD;
      end else begin
         if (wr_cmd) begin
            tape_command_register <= cmd_new;
         end
         if (wr_twr) begin
            tape_word_register <= (tape_word_register & ~wmask) | (w_data & wmask);
         end
         if (wr_blk) begin
            block_counter <= (block_counter & ~wmask) | (w_data & wmask);
         end else if (I_BLOCK_END && cur_op == OP_MOVE && state != ST_IDLE) begin
            block_counter <= block_counter - 32'h1;
         end
      end
   end

   // =======================================================================
   // Per-block parity check and status buffer
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         line_cnt <= 10'h000;
         blk_perr <= 1'b0;
         isb_perr <= 1'b0;
         read_ack <= 1'b0;
      end else begin
         read_ack <= blk_chk && !perr_now;
         if (I_BLOCK_END || stopping) begin
            line_cnt <= 10'h000;
            blk_perr <= 1'b0;
         end else if (I_LINE_VALID && line_cnt < 10'(`TFS_BLOCK_LINES)) begin
            line_cnt <= line_cnt + 10'h001;
            blk_perr <= blk_perr || I_LINE_PERR;
         end
         if (perr_stop) begin
            isb_perr <= 1'b1;
         end else if (rd_isb) begin
            isb_perr <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Latched fault conditions and delayed computer stop
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         temp_flt  <= 1'b0;
         b_flt     <= 5'h00;
         lockout   <= 1'b0;
         delay_cnt <= 24'h000000;
         delay_run <= 1'b0;
         b_stop    <= 1'b0;
      end else begin
         if (I_TEMP_FAULT) begin
            temp_flt <= 1'b1;
         end else if (I_CLEAR_A) begin
            temp_flt <= 1'b0;
         end
         b_flt <= b_flt | {I_READ_OVERRUN, I_SPROCKET_ERR, I_SELECT_ERR,
                           I_MISSING_DATA, I_INTERLOCK_FAULT};
         if (stop_nodrv) begin
            lockout <= 1'b1;
         end
         if (b_new && !delay_run && !b_stop) begin
            delay_run <= 1'b1;
            delay_cnt <= 24'(STOP_DELAY_CYC - 1);
         end else if (delay_run) begin
            if (delay_cnt == 24'h000000) begin
               delay_run <= 1'b0;
               b_stop    <= 1'b1;
            end else begin
               delay_cnt <= delay_cnt - 24'h000001;
            end
         end
      end
   end

   // =======================================================================
   // Program registers; a stalled instruction stays put during lockout
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         instruction_register <= `TFS_RST_WORD;
         next_address_counter <= `TFS_RST_WORD;
      end else begin
         if (wr_ir && !lockout) begin
            instruction_register <= (instruction_register & ~wmask) | (w_data & wmask);
         end
         if (wr_nac && !lockout) begin
            next_address_counter <= (next_address_counter & ~wmask) | (w_data & wmask);
         end
      end
   end

   // =======================================================================
   // AXI4-Lite slave
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         aw_addr <= 8'h00;
         aw_full <= 1'b0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
         w_full  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `TFS_RESP_OK;
      end else begin
         if (I_AWVALID && !aw_full) begin
            aw_addr <= I_AWADDR;
            aw_full <= 1'b1;
         end else if (do_wr) begin
            aw_full <= 1'b0;
         end
         if (I_WVALID && !w_full) begin
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
            w_full <= 1'b1;
         end else if (do_wr) begin
            w_full <= 1'b0;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `TFS_RESP_OK : `TFS_RESP_SLVERR;
         end else if (I_BREADY) begin
            bvalid <= 1'b0;
         end
      end
   end

   wire [31:0] flt_word = {18'h00000, state, lockout, b_stop, temp_flt, b_any,
                           b_flt[4], |b_flt[3:0], b_flt, 1'b0};
   wire        rd_hit   = I_ARADDR inside {`TFS_OFF_CMD, `TFS_OFF_TWR, `TFS_OFF_BLK,
                           `TFS_OFF_ISB, `TFS_OFF_FLT, `TFS_OFF_IR, `TFS_OFF_NAC};

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `TFS_RESP_OK;
      end else if (do_rd) begin
         rvalid <= 1'b1;
         rresp  <= rd_hit ? `TFS_RESP_OK : `TFS_RESP_SLVERR;
         case (I_ARADDR)
            `TFS_OFF_CMD: rdata <= tape_command_register;
            `TFS_OFF_TWR: rdata <= tape_word_register;
            `TFS_OFF_BLK: rdata <= block_counter;
            `TFS_OFF_ISB: rdata <= {31'h00000000, isb_perr};
            `TFS_OFF_FLT: rdata <= flt_word;
            `TFS_OFF_IR:  rdata <= instruction_register;
            `TFS_OFF_NAC: rdata <= next_address_counter;
            default:      rdata <= 32'h00000000;
         endcase
      end else if (I_RREADY) begin
         rvalid <= 1'b0;
      end
   end

   // =======================================================================
   // Outputs
   assign O_AWREADY       = !aw_full;
   assign O_WREADY        = !w_full;
   assign O_BVALID        = bvalid;
   assign O_BRESP         = bresp;
   assign O_ARREADY       = !rvalid;
   assign O_RVALID        = rvalid;
   assign O_RDATA         = rdata;
   assign O_RRESP         = rresp;
   assign O_TAPE_RUN      = state != ST_IDLE;
   assign O_DRIVE_SEL     = cur_drv;
   assign O_TAPE_STOP     = tape_stop;
   assign O_READ_ACK      = read_ack;
   assign O_A_FAULT       = temp_flt;
   assign O_B_STOP        = b_stop;
   assign O_TAPE_FLT_IND  = |b_flt[3:0];
   assign O_BUF_FAULT_IND = b_flt[4];
   assign O_WAIT_EXT      = lockout;

   // =======================================================================
   // Assertions
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);

   stop_clears_regs_a: assert property (stopping |=> tape_command_register == 32'h0
      && tape_word_register == 32'h0 && block_counter == 32'h0 && O_TAPE_STOP)
      else $error("tape registers not cleared at stop");
   halt_at_block_a: assert property (state == ST_HALT_BLK && !I_BLOCK_END
      |=> O_TAPE_RUN) else $error("fault stop before block end");
   fault_halts_a: assert property (state == ST_RUN && I_INTERLOCK_FAULT
      |=> state == ST_HALT_BLK ##0 b_any) else $error("fault did not start stop");
   stop_delay_a: assert property ($rose(b_stop) |-> $past(delay_run)
      && $past(delay_cnt) == 24'h0) else $error("computer stop not after delay");
   lockout_entry_a: assert property (stop_nodrv && state == ST_IDLE
      |=> O_WAIT_EXT && !O_TAPE_RUN) else $error("drive-less stop not locked out");
   ir_frozen_a: assert property (lockout |=> $stable(instruction_register))
      else $error("instruction changed in lockout");
   temp_class_a: assert property (I_TEMP_FAULT |=> O_A_FAULT ##0 !($rose(b_any)
      && !$past(b_new))) else $error("temp fault class wrong");
   b_class_a: assert property (I_MISSING_DATA || I_SELECT_ERR || I_SPROCKET_ERR
      |=> O_TAPE_FLT_IND [*2]) else $error("B fault not latched");
   parity_set_a: assert property (perr_stop |=> isb_perr && !O_TAPE_RUN
      && !O_READ_ACK) else $error("parity error not reported");
   parity_ok_a: assert property (blk_chk && !perr_now |=> O_READ_ACK
      && $stable(isb_perr)) else $error("clean block not acknowledged");
   parity_nofault_a: assert property (perr_stop && !b_any && !b_new
      |=> !b_any) else $error("parity raised computer fault");
   op_finish_a: assert property (state == ST_HALT_OP && !op_done && !b_new
      && !perr_stop |=> O_TAPE_RUN) else $error("long operation cut short");

   fault_stop_c: cover property (state == ST_HALT_BLK ##[1:20] O_TAPE_STOP);
   lockout_c:    cover property ($rose(lockout));
   parity_c:     cover property (perr_stop ##1 rd_isb);
   halt_op_c:    cover property (state == ST_HALT_OP ##[1:20] state == ST_IDLE);
endmodule : tfs_top

// ===== rtl/tfs_regs.svh
// Register map, field positions and timing counts of the tape fault/stop block
// Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access
`ifndef TFS_REGS_SVH
`define TFS_REGS_SVH
// ==========================================================================
// Register byte offsets
`define TFS_OFF_CMD        8'h00
`define TFS_OFF_TWR        8'h04
`define TFS_OFF_BLK        8'h08
`define TFS_OFF_ISB        8'h0c
`define TFS_OFF_FLT        8'h10
`define TFS_OFF_IR         8'h14
`define TFS_OFF_NAC        8'h18
// ==========================================================================
// Field positions
`define TFS_CMD_DRV_LSB    0
`define TFS_CMD_DRV_MSB    3
`define TFS_CMD_OP_LSB     4
`define TFS_CMD_OP_MSB     6
`define TFS_ISB_PERR       0
// ==========================================================================
// Reset values and responses
`define TFS_RST_WORD       32'h00000000
`define TFS_RESP_OK        2'h0
`define TFS_RESP_SLVERR    2'h2
// ==========================================================================
// Timing and block geometry
`define TFS_CLK_MHZ        100
`define TFS_STOP_DELAY_MS  80
`define TFS_STOP_DELAY_CYC (`TFS_STOP_DELAY_MS * 1000 * `TFS_CLK_MHZ)
`define TFS_BLOCK_LINES    720
`endif

// ===== rtl/tfs_pkg.sv
// Types shared by the tape fault/stop block
// Assumes nothing beyond the register header
package tfs_pkg;
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_RUN      = 2'b01,
      ST_HALT_BLK = 2'b10,
      ST_HALT_OP  = 2'b11
   } tfs_state_type;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_READ   = 3'b001,
      OP_WRITE  = 3'b010,
      OP_MOVE   = 3'b011,
      OP_REWIND = 3'b100,
      OP_STOP   = 3'b101
   } tfs_op_type;
endpackage : tfs_pkg

// ===== test/tfs_drive_model.sv
// Drive-side model: one tape line per clock while motion is commanded, then a gap
// Assumes the run level from the block and a test-selected parity error on line 5
module tfs_drive_model #(
   parameter int LINES = 720
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_run,
   input  wire logic i_bad_line,
   input  wire logic i_rewinding,
   output logic      o_block_end,
   output logic      o_line_valid,
   output logic      o_line_perr,
   output logic      o_rewind_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   assign o_rewind_done = o_block_end & i_rewinding;
   // ==========================================================================
   // Line stream and block gap
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= 0;
         o_block_end <= 1'b0;
         o_line_valid <= 1'b0;
         o_line_perr <= 1'b0;
      end else begin
         o_block_end <= i_run && cnt == LINES;
         o_line_valid <= i_run && cnt < LINES;
         o_line_perr <= i_run && i_bad_line && cnt == 5;
         cnt <= (i_run && cnt < LINES) ? cnt + 1 : 0;
      end
   end
endmodule : tfs_drive_model

// ===== test/tb.sv
// Self-checking bench for the tape fault/stop block over AXI4-Lite
// Assumes the drive model on the tape side and a shortened stop delay
`include "tfs_regs.svh"
module tb import tfs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 20;
   logic        clk = 0;
   logic        nrst = 0;
   logic [7:0]  awaddr = '0;
   logic [7:0]  araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        comp_stop = 0, clear_a = 0, rewinding = 0, bad_line = 0;
   logic [5:0]  flt = '0;
   wire         awready, wready, bvalid, arready, rvalid, blk_end, line_v, line_e;
   wire         rw_done, run, tstop, rack, afl, bstop, tf_ind, buf_ind, wait_ext;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [3:0]  drv;
   int          err_count = 0;
   int          n_checks = 0;
   logic [31:0] rd;
   logic [1:0]  rsp;
   always #5 clk = ~clk;
   tfs_top #(.STOP_DELAY_CYC(DLY)) dut (.I_SYS_CLK(clk), .I_NRST(nrst),
      .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
      .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(rready), .I_BLOCK_END(blk_end), .I_LINE_VALID(line_v),
      .I_LINE_PERR(line_e), .I_REWIND_DONE(rw_done), .I_COMP_STOP(comp_stop),
      .I_CLEAR_A(clear_a), .I_TEMP_FAULT(flt[0]), .I_INTERLOCK_FAULT(flt[1]),
      .I_MISSING_DATA(flt[2]), .I_SELECT_ERR(flt[3]), .I_SPROCKET_ERR(flt[4]),
      .I_READ_OVERRUN(flt[5]), .O_TAPE_RUN(run), .O_DRIVE_SEL(drv), .O_TAPE_STOP(tstop),
      .O_READ_ACK(rack), .O_A_FAULT(afl), .O_B_STOP(bstop), .O_TAPE_FLT_IND(tf_ind),
      .O_BUF_FAULT_IND(buf_ind), .O_WAIT_EXT(wait_ext));
   tfs_drive_model drv_m (.i_clk(clk), .i_nrst(nrst), .i_run(run), .i_bad_line(bad_line),
      .i_rewinding(rewinding), .o_block_end(blk_end), .o_line_valid(line_v),
      .o_line_perr(line_e), .o_rewind_done(rw_done));
   // ==========================================================================
   // Reporting
   task automatic close_out;
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic give_up(input logic ok);
      if (!ok) begin
         chk("timeout", 1, 0);
         close_out();
      end
   endtask : give_up
   // ==========================================================================
   // Bus and event helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 0;
      w_ok = 0;
      b_ok = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (int n = 0; n < 50 && !b_ok; n++) begin
         @(posedge clk);
         if (bvalid) begin
            b_ok = 1;
            rsp = bresp;
         end
         if (!aw_ok && awready) awvalid <= 0;
         if (!aw_ok && awready) aw_ok = 1;
         if (!w_ok && wready) wvalid <= 0;
         if (!w_ok && wready) w_ok = 1;
      end
      give_up(b_ok);
   endtask : wr
   task automatic rd_reg(input logic [7:0] a);
      logic ar_ok, r_ok;
      ar_ok = 0;
      r_ok = 0;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (int n = 0; n < 50 && !r_ok; n++) begin
         @(posedge clk);
         if (!ar_ok && arready) begin
            ar_ok = 1;
            arvalid <= 0;
         end else if (ar_ok && rvalid) begin
            r_ok = 1;
            rd = rdata;
            rsp = rresp;
         end
      end
      give_up(r_ok);
   endtask : rd_reg
   task automatic wait_sig(input logic want_stop);
      logic hit;
      hit = 0;
      for (int n = 0; n < 1600 && !hit; n++) begin
         @(posedge clk);
         hit = want_stop ? tstop : rack;
      end
      give_up(hit);
   endtask : wait_sig
   task automatic do_reset;
      nrst <= 0;
      repeat (16) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
   endtask : do_reset
   // ==========================================================================
   // Scenarios
   initial begin
      do_reset();
      rd_reg(`TFS_OFF_FLT);
      chk("flt_reset", 0, rd);
      rd_reg(8'h1c);
      chk("unmapped_rresp", `TFS_RESP_SLVERR, rsp);
      chk("unmapped_rdata", 0, rd);
      wr(8'h1c, 32'h1);
      chk("unmapped_bresp", `TFS_RESP_SLVERR, rsp);
      wr(`TFS_OFF_CMD, {25'h0, OP_READ, 4'h1});
      chk("run_read", 1, run);
      chk("drive_sel", 1, drv);
      wait_sig(0);
      rd_reg(`TFS_OFF_ISB);
      chk("status_clean", 0, rd);
      comp_stop <= 1;
      wait_sig(1);
      comp_stop <= 0;
      chk("run_cstop", 0, run);
      bad_line <= 1;
      wr(`TFS_OFF_CMD, {25'h0, OP_READ, 4'h1});
      wait_sig(1);
      chk("run_perr", 0, run);
      rd_reg(`TFS_OFF_ISB);
      chk("status_perr", 1, rd);
      wr(`TFS_OFF_CMD, {25'h0, OP_READ, 4'h1});
      wait_sig(1);
      bad_line <= 0;
      rd_reg(`TFS_OFF_ISB);
      chk("status_retry", 1, rd);
      repeat (DLY + 4) @(posedge clk);
      chk("perr_bstop", 0, {afl, bstop, tf_ind});
      wr(`TFS_OFF_CMD, {25'h0, OP_WRITE, 4'h2});
      wr(`TFS_OFF_TWR, 32'h5a);
      wr(`TFS_OFF_BLK, 32'h3);
      flt[1] <= 1;
      @(posedge clk);
      flt[1] <= 0;
      repeat (3) @(posedge clk);
      chk("run_to_block_end", 1, run);
      wait_sig(1);
      chk("run_fault", 0, run);
      rd_reg(`TFS_OFF_CMD);
      chk("cmd_cleared", 0, rd);
      rd_reg(`TFS_OFF_TWR);
      chk("twr_cleared", 0, rd);
      rd_reg(`TFS_OFF_BLK);
      chk("blk_cleared", 0, rd);
      chk("fault_bstop", 1, bstop);
      do_reset();
      wr(`TFS_OFF_IR, 32'h1234);
      wr(`TFS_OFF_CMD, {25'h0, OP_STOP, 4'h0});
      chk("lockout", 1, wait_ext);
      chk("no_motion", 0, run);
      wr(`TFS_OFF_IR, 32'h5678);
      rd_reg(`TFS_OFF_IR);
      chk("ir_held", 32'h1234, rd);
      do_reset();
      chk("lockout_clr", 0, wait_ext);
      wr(`TFS_OFF_BLK, 32'h2);
      wr(`TFS_OFF_CMD, {25'h0, OP_MOVE, 4'h3});
      comp_stop <= 1;
      repeat (800) @(posedge clk);
      chk("move_runs", 1, run);
      wait_sig(1);
      comp_stop <= 0;
      chk("move_done", 0, run);
      wr(`TFS_OFF_CMD, {25'h0, OP_MOVE, 4'h3});
      nrst <= 0;
      @(posedge clk);
      chk("mclear_halt", 0, run);
      for (int i = 0; i < 6; i++) begin
         do_reset();
         flt[i] <= 1;
         @(posedge clk);
         flt[i] <= 0;
         repeat (DLY - 2) @(posedge clk);
         chk("bstop_early", 0, bstop);
         repeat (4) @(posedge clk);
         chk("bstop_class", i != 0, bstop);
         chk("a_class", i == 0, afl);
         chk("tf_ind", i > 0 && i < 5, tf_ind);
         chk("buf_ind", i == 5, buf_ind);
         rd_reg(`TFS_OFF_FLT);
         chk("latch", 1, rd[i == 0 ? 9 : i]);
      end
      do_reset();
      chk("mclear_ind", 0, {tf_ind, buf_ind, bstop});
      flt[0] <= 1;
      @(posedge clk);
      flt[0] <= 0;
      repeat (4) @(posedge clk);
      clear_a <= 1;
      @(posedge clk);
      clear_a <= 0;
      repeat (2) @(posedge clk);
      chk("a_cleared", 0, afl);
      close_out();
   end
endmodule : tb
